//--- hw/csr_clock_source_receiver_status.sv
// Clock source selection, recovered clock control and receiver status registers
// How it works
// - Recovered clock divider field: 00 /1, 01 /2, 10 /4, 11 x2; resets 00.
// - Two-bit field tells the supplied oscillator range; 11 reserved.
// - Frame-clock bit makes the PLL lock to the aux port frame clock.
// - Source select 00 takes PLL, 01 takes oscillator, unlock ignored.
// - Source select 10 keeps the source currently in use.
// - Source select 11 follows unlock: PLL when locked, oscillator when not.
// - Manual PLL source unlocked: recovered clock from oscillator, timing invalid.
// - Force-lock set with source select 00: unlock does not swap oscillator onto recovered clock.
// - Force-lock lets PLL lock without oscillator and stops rate detection.
// - Force-lock makes the ratio register content invalid.
// - Force-lock makes the frequency code read 111.
// - Ratio is eight bits: two integer, six fraction bits.
// - Silence bit set after 1548 consecutive received zeros, else 0.
// - Three-bit stream format code as detected, 100 multichannel data.
// - Active source bit: 0 PLL, 1 oscillator.
// - Three-bit code of nearest listed recovered clock frequency.
// - Preamble bytes readable at indices 09h to 0Ch, read only.
// - Received preamble bytes load into the four preamble registers.
// - Force-lock with de-emphasis on uses the manual rate field.
`timescale 1ns/100ps

module csr_clock_source_receiver_status
   import csr_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic ce_in,
   input wire csr_apb_req_t apb_req_in,
   output csr_apb_rsp_t apb_rsp_out,
   input wire logic pll_unlock_in,
   input wire logic osc_tick_in,
   input wire logic pll_tick_in,
   input wire logic rx_bit_valid_in,
   input wire logic rx_bit_in,
   input wire logic [2:0] stream_format_in,
   input wire logic [1:0] detected_rate_in,
   input wire logic preamble_valid_in,
   input wire csr_preamble_t preamble_in,
   output csr_clk_ctl_t clk_ctl_out,
   output logic [2:0] recovered_clock_frequency_code_out,
   output logic digital_silence_out
);

   // ==========================================================
   // State record
   typedef struct packed {
      logic unlock_s1;
      logic unlock_s2;
      logic unlock_s3;
      logic unlock;
      csr_src_t src;
      logic [7:0] clock_control;
      logic [7:0] deemph_control;
      logic [10:0] zero_count;
      logic silence;
      logic [2:0] stream_format;
      logic [5:0] window_count;
      logic [7:0] osc_count;
      logic [7:0] ratio;
      logic [2:0] freq_code;
      csr_preamble_t preamble;
      csr_bus_t bus;
      csr_apb_rsp_t rsp;
      csr_clk_ctl_t ctl;
   } csr_state_t;

   csr_state_t state;
   csr_state_t next_state;

   // ==========================================================
   // Helper functions

   // Byte address of a register index
   function automatic logic [CSR_ADDR_W-1:0] reg_addr(input logic [7:0] idx);
      reg_addr = {{(CSR_ADDR_W-10){1'b0}}, idx, 2'b00};
   endfunction

   // Saturating increment for the eight-bit counts
   function automatic logic [7:0] sat_inc8(input logic [7:0] value);
      if (value == CSR_RATIO_MAX) begin
         sat_inc8 = value;
      end else begin
         sat_inc8 = value + 8'h01;
      end
   endfunction

   // Bring a ratio count to the 12.288 MHz scale of the thresholds
   function automatic logic [7:0] scale_ratio(input logic [7:0] ratio, input logic [1:0] range);
      logic [9:0] doubled;
      doubled = {1'b0, ratio, 1'b0};
      case (range)
         CSR_FREQ_18M: scale_ratio = 8'(doubled / 10'd3);
         CSR_FREQ_24M: scale_ratio = {1'b0, ratio[7:1]};
         default: scale_ratio = ratio;
      endcase
   endfunction

   // Nearest listed frequency; bigger ratio means slower PLL clock
   function automatic logic [2:0] nearest_code(input logic [7:0] scaled);
      if (scaled >= CSR_THR_0) begin
         nearest_code = 3'h0;
      end else if (scaled >= CSR_THR_1) begin
         nearest_code = 3'h1;
      end else if (scaled >= CSR_THR_2) begin
         nearest_code = 3'h2;
      end else if (scaled >= CSR_THR_3) begin
         nearest_code = 3'h3;
      end else if (scaled >= CSR_THR_4) begin
         nearest_code = 3'h4;
      end else if (scaled >= CSR_THR_5) begin
         nearest_code = 3'h5;
      end else if (scaled >= CSR_THR_6) begin
         nearest_code = 3'h6;
      end else begin
         nearest_code = 3'h7;
      end
   endfunction

   // ==========================================================
   // Field views of the control registers
   logic [1:0] divider;
   logic [1:0] osc_range;
   logic frame_lock;
   logic [1:0] source_select;
   logic force_lock;
   logic deemph_enable;
   logic [1:0] manual_deemphasis_rate;

   // Field slices of the writable registers
   always_comb begin
      divider = state.clock_control[CSR_CC_DIV_LSB +: 2];
      osc_range = state.clock_control[CSR_CC_FREQ_LSB +: 2];
      frame_lock = state.clock_control[CSR_CC_LRCK_BIT];
      source_select = state.clock_control[CSR_CC_SEL_LSB +: 2];
      force_lock = state.clock_control[CSR_CC_FORCE_BIT];
      deemph_enable = state.deemph_control[CSR_DM_EN_BIT];
      manual_deemphasis_rate = state.deemph_control[CSR_DM_RATE_LSB +: 2];
   end

   // ==========================================================
   // Bus decode
   logic bus_access;
   logic [7:0] read_byte;
   logic addr_hit;

   // Read mux; reads only select, nothing changes on a read
   always_comb begin
      read_byte = 8'h00;
      addr_hit = 1'b1;
      case (apb_req_in.paddr)
         reg_addr(CSR_IDX_CLOCK_CONTROL): read_byte = state.clock_control;
         reg_addr(CSR_IDX_RATIO): read_byte = force_lock ? 8'h00 : state.ratio;
         reg_addr(CSR_IDX_RECEIVER_STATUS): begin
            read_byte[CSR_ST_SILENCE_BIT] = state.silence;
            read_byte[CSR_ST_FMT_LSB +: 3] = state.stream_format;
            read_byte[CSR_ST_ACTIVE_BIT] = (state.src == CSR_SRC_OSC);
            read_byte[CSR_ST_CODE_LSB +: 3] = state.freq_code;
         end
         reg_addr(CSR_IDX_PC_HIGH): read_byte = state.preamble.pc[15:8];
         reg_addr(CSR_IDX_PC_LOW): read_byte = state.preamble.pc[7:0];
         reg_addr(CSR_IDX_PD_HIGH): read_byte = state.preamble.pd[15:8];
         reg_addr(CSR_IDX_PD_LOW): read_byte = state.preamble.pd[7:0];
         reg_addr(CSR_IDX_DEEMPH_CONTROL): read_byte = state.deemph_control;
         default: addr_hit = 1'b0;
      endcase
   end

   // Access phase seen while no answer is standing
   always_comb begin
      bus_access = apb_req_in.psel && apb_req_in.penable && (state.bus == CSR_BUS_IDLE);
   end

   // ==========================================================
   // Next state
   always_comb begin
      logic src_pll_unlocked;
      logic [7:0] scaled;
      src_pll_unlocked = 1'b0;
      scaled = 8'h00;
      next_state = state;

      // Unlock pin: three stages, level moves once stages two and three agree
      next_state.unlock_s1 = pll_unlock_in;
      next_state.unlock_s2 = state.unlock_s1;
      next_state.unlock_s3 = state.unlock_s2;
      if (state.unlock_s2 == state.unlock_s3) begin
         next_state.unlock = state.unlock_s3;
      end

      // Bus: one wait cycle, answer stands one cycle, then released
      next_state.rsp.pready = 1'b0;
      next_state.rsp.pslverr = 1'b0;
      next_state.bus = CSR_BUS_IDLE;
      if (bus_access) begin
         next_state.bus = CSR_BUS_DONE;
         next_state.rsp.pready = 1'b1;
         next_state.rsp.pslverr = !addr_hit;
         next_state.rsp.prdata = apb_req_in.pwrite ? 32'h00000000 : {24'h000000, read_byte};
         if (apb_req_in.pwrite) begin
            case (apb_req_in.paddr)
               reg_addr(CSR_IDX_CLOCK_CONTROL): begin
                  next_state.clock_control = apb_req_in.pwdata[7:0];
               end
               reg_addr(CSR_IDX_DEEMPH_CONTROL): begin
                  next_state.deemph_control = apb_req_in.pwdata[7:0];
               end
               default: begin
               end
            endcase
         end
      end

      // Master clock source selection
      case (source_select)
         CSR_SEL_PLL: next_state.src = CSR_SRC_PLL;
         CSR_SEL_OSC: next_state.src = CSR_SRC_OSC;
         CSR_SEL_HOLD: next_state.src = state.src;
         CSR_SEL_AUTO: next_state.src = state.unlock ? CSR_SRC_OSC : CSR_SRC_PLL;
         default: next_state.src = state.src;
      endcase

      // Digital silence: count consecutive zero bits, any one restarts
      if (rx_bit_valid_in) begin
         if (rx_bit_in) begin
            next_state.zero_count = 11'h000;
         end else if (state.zero_count != CSR_SILENCE_ZEROS) begin
            next_state.zero_count = state.zero_count + 11'h001;
         end
      end
      next_state.silence = (next_state.zero_count == CSR_SILENCE_ZEROS);

      next_state.stream_format = stream_format_in;

      if (preamble_valid_in) begin
         next_state.preamble = preamble_in;
      end

      // Ratio: oscillator ticks over 64 PLL ticks gives ratio times 64
      // two integer, six fraction bits
      if (force_lock) begin
         // measuring stopped, window restarts on release
         next_state.window_count = 6'h00;
         next_state.osc_count = 8'h00;
      end else begin
         if (osc_tick_in) begin
            next_state.osc_count = sat_inc8(state.osc_count);
         end
         if (pll_tick_in) begin
            if (state.window_count == CSR_RATIO_WINDOW_LAST) begin
               next_state.ratio = next_state.osc_count;
               next_state.window_count = 6'h00;
               next_state.osc_count = 8'h00;
            end else begin
               next_state.window_count = state.window_count + 6'h01;
            end
         end
      end

      // nearest frequency code from the ratio and oscillator range
      scaled = scale_ratio(state.ratio, osc_range);
      if (force_lock) begin
         next_state.freq_code = CSR_CODE_FORCED;
      end else begin
         next_state.freq_code = nearest_code(scaled);
      end

      // Clock control outputs
      // divider to the clock generator
      next_state.ctl.recovered_clock_divider = divider;
      next_state.ctl.oscillator_frequency_range = osc_range;
      next_state.ctl.pll_lock_to_frame_clock = frame_lock;
      next_state.ctl.mclk_from_oscillator = (next_state.src == CSR_SRC_OSC);
      // unlocked PLL on manual source; force-lock keeps the PLL clock
      src_pll_unlocked = (source_select == CSR_SEL_PLL) && state.unlock && !force_lock;
      next_state.ctl.recovered_master_clock_from_osc =
         (next_state.src == CSR_SRC_OSC) || src_pll_unlocked;
      next_state.ctl.timing_valid = !src_pll_unlocked;
      next_state.ctl.pll_lock_without_osc = force_lock;
      next_state.ctl.auto_rate_detect_enable = !force_lock;
      next_state.ctl.deemph_filter_enable = deemph_enable;
      next_state.ctl.deemph_filter_rate = force_lock ? manual_deemphasis_rate : detected_rate_in;
   end

   // ==========================================================
   // Register the state; clock enable low freezes everything
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         state <= '0;
         state.src <= CSR_SRC_PLL;
         state.bus <= CSR_BUS_IDLE;
         state.clock_control <= CSR_CC_RESET;
         state.deemph_control <= CSR_DM_RESET;
         state.ctl.timing_valid <= 1'b1;
         state.ctl.auto_rate_detect_enable <= 1'b1;
      end else if (ce_in) begin
         state <= next_state;
      end
   end

   // ==========================================================
   // Outputs straight from the state record
   assign apb_rsp_out = state.rsp;
   assign clk_ctl_out = state.ctl;
   assign recovered_clock_frequency_code_out = state.freq_code;
   assign digital_silence_out = state.silence;

endmodule

//--- hw/csr_pkg.sv
// Shared constants and carrier types of the clock source and receiver status block
package csr_pkg;

   // ==========================================================
   // Register indices (byte address is four times the index)
   localparam logic [7:0] CSR_IDX_CLOCK_CONTROL = 8'h06;
   localparam logic [7:0] CSR_IDX_RATIO = 8'h07;
   localparam logic [7:0] CSR_IDX_RECEIVER_STATUS = 8'h08;
   localparam logic [7:0] CSR_IDX_PC_HIGH = 8'h09;
   localparam logic [7:0] CSR_IDX_PC_LOW = 8'h0a;
   localparam logic [7:0] CSR_IDX_PD_HIGH = 8'h0b;
   localparam logic [7:0] CSR_IDX_PD_LOW = 8'h0c;
   localparam logic [7:0] CSR_IDX_DEEMPH_CONTROL = 8'h1f;
   localparam int CSR_ADDR_W = 12;

   // ==========================================================
   // Field positions and reset values
   localparam int CSR_CC_DIV_LSB = 6;
   localparam int CSR_CC_FREQ_LSB = 4;
   localparam int CSR_CC_LRCK_BIT = 3;
   localparam int CSR_CC_SEL_LSB = 1;
   localparam int CSR_CC_FORCE_BIT = 0;
   localparam logic [7:0] CSR_CC_RESET = 8'h00;
   localparam int CSR_ST_SILENCE_BIT = 7;
   localparam int CSR_ST_FMT_LSB = 4;
   localparam int CSR_ST_ACTIVE_BIT = 3;
   localparam int CSR_ST_CODE_LSB = 0;
   localparam int CSR_DM_EN_BIT = 0;
   localparam int CSR_DM_RATE_LSB = 4;
   localparam logic [7:0] CSR_DM_RESET = 8'h00;

   // ==========================================================
   // Field encodings
   localparam logic [1:0] CSR_SEL_PLL = 2'h0;
   localparam logic [1:0] CSR_SEL_OSC = 2'h1;
   localparam logic [1:0] CSR_SEL_HOLD = 2'h2;
   localparam logic [1:0] CSR_SEL_AUTO = 2'h3;
   localparam logic [1:0] CSR_FREQ_12M = 2'h0;
   localparam logic [1:0] CSR_FREQ_18M = 2'h1;
   localparam logic [1:0] CSR_FREQ_24M = 2'h2;
   localparam logic [2:0] CSR_CODE_FORCED = 3'h7;

   // ==========================================================
   // Timing counts
   localparam logic [10:0] CSR_SILENCE_ZEROS = 11'h60c;
   localparam logic [5:0] CSR_RATIO_WINDOW_LAST = 6'h3f;
   localparam logic [7:0] CSR_RATIO_MAX = 8'hff;

   // Ratio thresholds (12.288 MHz scale) between neighbouring frequency codes
   localparam logic [7:0] CSR_THR_0 = 8'h51;
   localparam logic [7:0] CSR_THR_1 = 8'h43;
   localparam logic [7:0] CSR_THR_2 = 8'h37;
   localparam logic [7:0] CSR_THR_3 = 8'h29;
   localparam logic [7:0] CSR_THR_4 = 8'h22;
   localparam logic [7:0] CSR_THR_5 = 8'h17;
   localparam logic [7:0] CSR_THR_6 = 8'h11;

   // ==========================================================
   // Carrier types
   typedef enum logic {CSR_SRC_PLL, CSR_SRC_OSC} csr_src_t;
   typedef enum logic [1:0] {CSR_BUS_IDLE, CSR_BUS_DONE} csr_bus_t;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [CSR_ADDR_W-1:0] paddr;
      logic [31:0] pwdata;
   } csr_apb_req_t;

   typedef struct packed {
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } csr_apb_rsp_t;

   typedef struct packed {
      logic [1:0] recovered_clock_divider;
      logic [1:0] oscillator_frequency_range;
      logic pll_lock_to_frame_clock;
      logic mclk_from_oscillator;
      logic recovered_master_clock_from_osc;
      logic timing_valid;
      logic pll_lock_without_osc;
      logic auto_rate_detect_enable;
      logic [1:0] deemph_filter_rate;
      logic deemph_filter_enable;
   } csr_clk_ctl_t;

   typedef struct packed {
      logic [15:0] pc;
      logic [15:0] pd;
   } csr_preamble_t;

endpackage

//--- testbench/csr_checker.sv
// Port-level assertions for the clock source and receiver status block
`timescale 1ns/100ps

module csr_checker
   import csr_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic ce_in,
   input wire csr_apb_req_t apb_req_in,
   input wire csr_apb_rsp_t apb_rsp_out,
   input wire logic rx_bit_valid_in,
   input wire logic rx_bit_in,
   input wire csr_clk_ctl_t clk_ctl_out,
   input wire logic [2:0] recovered_clock_frequency_code_out,
   input wire logic digital_silence_out
);
   // ==========================================================
   // Zero run length, saturating so a long silence cannot wrap
   logic [11:0] zero_run;
   logic [11:0] next_zero_run;

   always_comb begin
      next_zero_run = zero_run;
      if (ce_in && rx_bit_valid_in) begin
         if (rx_bit_in) begin
            next_zero_run = 12'h000;
         end else if (zero_run != 12'hfff) begin
            next_zero_run = zero_run + 12'h001;
         end
      end
   end

   // Same edge as the design register, so both compare directly
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         zero_run <= 12'h000;
      end else begin
         zero_run <= next_zero_run;
      end
   end

   // ==========================================================
   // Assertions
   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);

   chk_ready_wait: assert property (
      (apb_req_in.psel && apb_req_in.penable && !apb_rsp_out.pready && ce_in)
      |=> apb_rsp_out.pready) else $error("No answer one cycle after access");
   chk_ready_pulse: assert property (
      apb_rsp_out.pready |=> !apb_rsp_out.pready) else $error("Ready held two cycles");
   chk_err_ready: assert property (
      apb_rsp_out.pslverr |-> apb_rsp_out.pready) else $error("Slave error without ready");
   chk_read_upper: assert property (
      apb_rsp_out.pready |-> (apb_rsp_out.prdata[31:8] == 24'h000000))
      else $error("Upper read data not zero");
   chk_force_code: assert property (
      clk_ctl_out.pll_lock_without_osc [*3] |-> (recovered_clock_frequency_code_out == 3'h7))
      else $error("Frequency code not 111 under forced lock");
   chk_force_rate: assert property (
      clk_ctl_out.auto_rate_detect_enable == !clk_ctl_out.pll_lock_without_osc)
      else $error("Rate detection not tied to forced lock");
   chk_force_no_osc: assert property (
      clk_ctl_out.pll_lock_without_osc [*2] |-> !clk_ctl_out.recovered_master_clock_from_osc)
      else $error("Oscillator swapped in under forced lock");
   chk_invalid_timing: assert property (
      !clk_ctl_out.timing_valid |-> (clk_ctl_out.recovered_master_clock_from_osc
      && !clk_ctl_out.mclk_from_oscillator)) else $error("Invalid timing without PLL fallback");
   chk_silence_count: assert property (
      digital_silence_out == (zero_run >= {1'b0, CSR_SILENCE_ZEROS}))
      else $error("Silence flag disagrees with zero run");
   chk_one_clears: assert property (
      (ce_in && rx_bit_valid_in && rx_bit_in) |=> !digital_silence_out)
      else $error("Silence flag kept after a one");
endmodule

bind csr_clock_source_receiver_status csr_checker u_chk (
   .clk_in(clk_in),
   .rst_in(rst_in),
   .ce_in(ce_in),
   .apb_req_in(apb_req_in),
   .apb_rsp_out(apb_rsp_out),
   .rx_bit_valid_in(rx_bit_valid_in),
   .rx_bit_in(rx_bit_in),
   .clk_ctl_out(clk_ctl_out),
   .recovered_clock_frequency_code_out(recovered_clock_frequency_code_out),
   .digital_silence_out(digital_silence_out)
);

//--- testbench/tb.sv
// Self-checking bench for the clock source and receiver status block
`timescale 1ns/100ps

module tb
   import csr_pkg::*;
();
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic unlock = 1'b0;
   logic osc_tick = 1'b0;
   logic pll_tick = 1'b0;
   logic rx_valid = 1'b0;
   logic rx_bit = 1'b0;
   logic pre_valid = 1'b0;
   logic [2:0] fmt = 3'h0;
   logic [1:0] det_rate = 2'h3;
   logic [2:0] ph = 3'h0;
   logic [1:0] mode = 2'h0;
   logic [7:0] q;
   logic err;
   logic [2:0] code;
   logic silence;
   csr_apb_req_t req = '0;
   csr_apb_rsp_t rsp;
   csr_preamble_t pre = '0;
   csr_clk_ctl_t ctl;
   int n_fail = 0;
   int cmp_count = 0;

   // ==========================================================
   // Clock and tick patterns: mode 1 gives ratio 1.5, mode 2 gives 0.5
   always #2.5 clk_in = ~clk_in;

   always @(posedge clk_in) begin
      ph <= (ph == 3'h5) ? 3'h0 : ph + 3'h1;
      pll_tick <= (mode == 2'h2) || (mode == 2'h1 && (ph == 3'h0 || ph == 3'h3));
      osc_tick <= (mode != 2'h0) && !ph[0];
   end

   csr_clock_source_receiver_status u_dut (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .ce_in(1'b1),
      .apb_req_in(req),
      .apb_rsp_out(rsp),
      .pll_unlock_in(unlock),
      .osc_tick_in(osc_tick),
      .pll_tick_in(pll_tick),
      .rx_bit_valid_in(rx_valid),
      .rx_bit_in(rx_bit),
      .stream_format_in(fmt),
      .detected_rate_in(det_rate),
      .preamble_valid_in(pre_valid),
      .preamble_in(pre),
      .clk_ctl_out(ctl),
      .recovered_clock_frequency_code_out(code),
      .digital_silence_out(silence)
   );

   // ==========================================================
   // Tasks
   task automatic wrap_up();
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Answer taken at the rising edge that sees pready high, then released
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] d);
      int i;
      @(posedge clk_in);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: {2'h0, idx, 2'h0},
               pwdata: {24'h0, d}};
      @(posedge clk_in);
      req.penable <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge clk_in);
         if (rsp.pready === 1'b1) break;
      end
      if (i == 50) begin
         n_fail++;
         wrap_up();
      end
      q = rsp.prdata[7:0];
      err = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
      apb(1'b0, idx, 8'h00);
      check({err, q}, {1'b0, exp});
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_in);
   endtask

   // Hang guard
   initial begin
      repeat (100000) @(posedge clk_in);
      n_fail++;
      wrap_up();
   end

   // ==========================================================
   // Main sequence
   initial begin
      cyc(16);
      rst_in <= 1'b0;
      rd(CSR_IDX_CLOCK_CONTROL, CSR_CC_RESET);
      rd(CSR_IDX_RECEIVER_STATUS, 8'h07);
      check(ctl.timing_valid, 1'b1);
      // Divider, oscillator range and frame clock lock fields
      for (int k = 0; k < 4; k++) begin
         apb(1'b1, CSR_IDX_CLOCK_CONTROL, {k[1:0], k[1:0], k[0], 3'h0});
         cyc(2);
         check(ctl.recovered_clock_divider, k[1:0]);
         check(ctl.pll_lock_to_frame_clock, k[0]);
         if (k < 3) check(ctl.oscillator_frequency_range, k[1:0]);
         rd(CSR_IDX_CLOCK_CONTROL, {k[1:0], k[1:0], k[0], 3'h0});
      end
      // Manual, automatic and hold source selection
      apb(1'b1, CSR_IDX_CLOCK_CONTROL, 8'h02);
      cyc(2);
      check(ctl.mclk_from_oscillator, 1'b1);
      rd(CSR_IDX_RECEIVER_STATUS, 8'h0f);
      unlock <= 1'b1;
      apb(1'b1, CSR_IDX_CLOCK_CONTROL, 8'h00);
      cyc(8);
      check({ctl.mclk_from_oscillator, ctl.recovered_master_clock_from_osc}, 2'h1);
      check(ctl.timing_valid, 1'b0);
      apb(1'b1, CSR_IDX_CLOCK_CONTROL, 8'h06);
      cyc(2);
      check(ctl.mclk_from_oscillator, 1'b1);
      unlock <= 1'b0;
      cyc(8);
      check(ctl.mclk_from_oscillator, 1'b0);
      apb(1'b1, CSR_IDX_CLOCK_CONTROL, 8'h04);
      unlock <= 1'b1;
      cyc(8);
      check(ctl.mclk_from_oscillator, 1'b0);
      apb(1'b1, CSR_IDX_CLOCK_CONTROL, 8'h02);
      apb(1'b1, CSR_IDX_CLOCK_CONTROL, 8'h04);
      unlock <= 1'b0;
      cyc(8);
      check(ctl.mclk_from_oscillator, 1'b1);
      // Forced lock while unlocked, manual de-emphasis rate
      unlock <= 1'b1;
      apb(1'b1, CSR_IDX_CLOCK_CONTROL, 8'h01);
      apb(1'b1, CSR_IDX_DEEMPH_CONTROL, 8'h11);
      cyc(8);
      check(code, 3'h7);
      check({ctl.pll_lock_without_osc, ctl.auto_rate_detect_enable}, 2'h2);
      check(ctl.recovered_master_clock_from_osc, 1'b0);
      check({ctl.deemph_filter_enable, ctl.deemph_filter_rate}, 3'h5);
      rd(CSR_IDX_RATIO, 8'h00);
      rd(CSR_IDX_RECEIVER_STATUS, 8'h07);
      apb(1'b1, CSR_IDX_CLOCK_CONTROL, 8'h00);
      unlock <= 1'b0;
      cyc(8);
      check(ctl.deemph_filter_rate, det_rate);
      // Ratio and frequency code: 1.5 and 0.5 at range 00, 1.5 at range 01
      for (int k = 0; k < 3; k++) begin
         mode <= (k == 1) ? 2'h2 : 2'h1;
         apb(1'b1, CSR_IDX_CLOCK_CONTROL, {2'h0, (k == 2) ? 2'h1 : 2'h0, 4'h0});
         cyc(700);
         rd(CSR_IDX_RATIO, (k == 1) ? 8'h20 : 8'h60);
         check(code, (k == 0) ? 3'h0 : ((k == 1) ? 3'h5 : 3'h2));
      end
      mode <= 2'h0;
      // Silence threshold and release
      rx_valid <= 1'b1;
      cyc(1547);
      @(negedge clk_in);
      check(silence, 1'b0);
      @(negedge clk_in);
      check(silence, 1'b1);
      @(posedge clk_in);
      rx_valid <= 1'b0;
      apb(1'b0, CSR_IDX_RECEIVER_STATUS, 8'h00);
      check(q[7], 1'b1);
      rx_valid <= 1'b1;
      rx_bit <= 1'b1;
      @(posedge clk_in);
      rx_valid <= 1'b0;
      @(negedge clk_in);
      check(silence, 1'b0);
      // Every stream format code
      for (int f = 0; f < 8; f++) begin
         fmt <= f[2:0];
         cyc(2);
         apb(1'b0, CSR_IDX_RECEIVER_STATUS, 8'h00);
         check(q[6:4], f[2:0]);
      end
      // Preamble bytes, writes to read-only places, unmapped address
      pre <= '{pc: 16'ha1b2, pd: 16'hc3d4};
      pre_valid <= 1'b1;
      cyc(1);
      pre_valid <= 1'b0;
      for (int k = 0; k < 4; k++) begin
         rd(CSR_IDX_PC_HIGH + 8'(k), 8'(32'ha1b2c3d4 >> (24 - 8 * k)));
      end
      apb(1'b1, CSR_IDX_PC_HIGH, 8'h00);
      apb(1'b1, CSR_IDX_RATIO, 8'hff);
      rd(CSR_IDX_PC_HIGH, 8'ha1);
      rd(CSR_IDX_RATIO, 8'h60);
      apb(1'b1, 8'h40, 8'h5a);
      check(err, 1'b1);
      // Second reset in mid-run
      apb(1'b1, CSR_IDX_CLOCK_CONTROL, 8'hc0);
      rst_in <= 1'b1;
      cyc(2);
      rst_in <= 1'b0;
      rd(CSR_IDX_CLOCK_CONTROL, CSR_CC_RESET);
      wrap_up();
   end
endmodule
